// ===== rtl/afrmux_consts.svh
// Constants for the alternate function remap multiplexer.
// Summary of operation
// RULE1 - Eight option bits, bit n selects option n
// RULE2 - Cleared option keeps default alternate function
// RULE3 - Option 7 puts beeper on D4
// RULE4 - Option 6 puts I2C data B5, clock B4
// RULE5 - Option 5 puts advanced timer set on B3..B0
// RULE6 - Option 4 puts timer channel 4 on D7
// RULE7 - Option 3 puts break input on D0
// RULE8 - Option 2 puts clock output on D0
// RULE9 - Option 2 wins over option 3 on D0
// RULE10 - Option 1 puts timer channels on A3, D2
// RULE11 - Option 0 puts converter trigger on D3
// RULE12 - Software enables one option per port only; the option register accepts any combination of the eight bits
// RULE13 - Active option removes default function from pin
// RULE14 - Peripheral must be enabled by its own registers
// RULE15 - Options latched at reset release, held until reset
`ifndef AFRMUX_CONSTS_SVH
`define AFRMUX_CONSTS_SVH

// ********************************************************************
// Register map
// ********************************************************************
`define AFRMUX_OFS_OPTIONS   12'h000
`define AFRMUX_OFS_ACTIVE    12'h004
`define AFRMUX_OFS_PINSEL    12'h008
`define AFRMUX_OPTIONS_RST   8'h00

// ********************************************************************
// Option bit positions
// ********************************************************************
`define AFRMUX_BIT_CONV_TRIG 0
`define AFRMUX_BIT_GPTIMER   1
`define AFRMUX_BIT_CLK_OUT   2
`define AFRMUX_BIT_BREAK     3
`define AFRMUX_BIT_CH4       4
`define AFRMUX_BIT_ADV_PORTB 5
`define AFRMUX_BIT_TWOWIRE   6
`define AFRMUX_BIT_BEEPER    7

`endif

// ===== rtl/afrmux_pkg.sv
// Types shared by the alternate function remap multiplexer.
package afrmux_pkg;
  // Function routed onto port D pin 0.
  typedef enum logic [1:0] {
    AFRMUX_D0_DEFAULT,
    AFRMUX_D0_BREAK,
    AFRMUX_D0_CLKOUT
  } afrmux_d0_sel_t;
endpackage

// ===== rtl/afrmux_route.sv
// Combinational pin routing for one set of remap options.
`timescale 1ns/1ps
module afrmux_route
  import afrmux_pkg::*;
(
  input  wire logic [7:0]  opts,
  input  wire logic [7:0]  dflt_a,
  input  wire logic [7:0]  dflt_b,
  input  wire logic [7:0]  dflt_d,
  input  wire logic        beeper_output,
  input  wire logic        twowire_sda,
  input  wire logic        twowire_scl,
  input  wire logic        advtimer_ext_trigger,
  input  wire logic        advtimer_comp_out3,
  input  wire logic        advtimer_comp_out2,
  input  wire logic        advtimer_comp_out1,
  input  wire logic        advtimer_channel4,
  input  wire logic        advtimer_break_in,
  input  wire logic        configurable_clock_out,
  input  wire logic        gptimer_b_channel1,
  input  wire logic        gptimer_a_channel3,
  input  wire logic        converter_ext_trigger,
  output logic      [7:0]  af_a,
  output logic      [7:0]  af_b,
  output logic      [7:0]  af_d,
  output logic      [7:0]  remap_mask_a,
  output logic      [7:0]  remap_mask_b,
  output logic      [7:0]  remap_mask_d,
  output afrmux_d0_sel_t   d0_sel
);
  `include "afrmux_consts.svh"

  always_comb begin
    // Default alternate functions stand wherever no option claims the pin.
    af_a         = dflt_a; // see RULE2
    af_b         = dflt_b; // see RULE2
    af_d         = dflt_d; // see RULE2
    remap_mask_a = 8'h00;
    remap_mask_b = 8'h00;
    remap_mask_d = 8'h00;
    d0_sel       = AFRMUX_D0_DEFAULT;
    if (opts[`AFRMUX_BIT_BEEPER]) begin
      af_d[4] = beeper_output; // see RULE3
      remap_mask_d[4] = 1'b1; // see RULE13
    end
    if (opts[`AFRMUX_BIT_TWOWIRE]) begin
      af_b[5] = twowire_sda; // see RULE4
      af_b[4] = twowire_scl; // see RULE4
      remap_mask_b[5:4] = 2'h3;
    end
    if (opts[`AFRMUX_BIT_ADV_PORTB]) begin
      af_b[3] = advtimer_ext_trigger; // see RULE5
      af_b[2] = advtimer_comp_out3; // see RULE5
      af_b[1] = advtimer_comp_out2; // see RULE5
      af_b[0] = advtimer_comp_out1; // see RULE5
      remap_mask_b[3:0] = 4'hF;
    end
    if (opts[`AFRMUX_BIT_CH4]) begin
      af_d[7] = advtimer_channel4; // see RULE6
      remap_mask_d[7] = 1'b1;
    end
    // Clock output is tested first so it wins the shared pin.
    if (opts[`AFRMUX_BIT_CLK_OUT]) begin
      af_d[0] = configurable_clock_out; // see RULE8 see RULE9
      remap_mask_d[0] = 1'b1;
      d0_sel = AFRMUX_D0_CLKOUT;
    end else if (opts[`AFRMUX_BIT_BREAK]) begin
      af_d[0] = advtimer_break_in; // see RULE7
      remap_mask_d[0] = 1'b1;
      d0_sel = AFRMUX_D0_BREAK;
    end
    if (opts[`AFRMUX_BIT_GPTIMER]) begin
      af_a[3] = gptimer_b_channel1; // see RULE10
      af_d[2] = gptimer_a_channel3; // see RULE10
      remap_mask_a[3] = 1'b1;
      remap_mask_d[2] = 1'b1;
    end
    if (opts[`AFRMUX_BIT_CONV_TRIG]) begin
      af_d[3] = converter_ext_trigger; // see RULE11
      remap_mask_d[3] = 1'b1;
    end
  end
endmodule // afrmux_route

// ===== rtl/afrmux_top.sv
// Alternate function remap multiplexer with APB option register.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module afrmux_top
  import afrmux_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  dflt_a,
  input  wire logic [7:0]  dflt_b,
  input  wire logic [7:0]  dflt_d,
  input  wire logic        beeper_output,
  input  wire logic        twowire_sda,
  input  wire logic        twowire_scl,
  input  wire logic        advtimer_ext_trigger,
  input  wire logic        advtimer_comp_out3,
  input  wire logic        advtimer_comp_out2,
  input  wire logic        advtimer_comp_out1,
  input  wire logic        advtimer_channel4,
  input  wire logic        advtimer_break_in,
  input  wire logic        configurable_clock_out,
  input  wire logic        gptimer_b_channel1,
  input  wire logic        gptimer_a_channel3,
  input  wire logic        converter_ext_trigger,
  output logic      [7:0]  af_a,
  output logic      [7:0]  af_b,
  output logic      [7:0]  af_d,
  output logic      [7:0]  remap_mask_a,
  output logic      [7:0]  remap_mask_b,
  output logic      [7:0]  remap_mask_d
);
  `include "afrmux_consts.svh"

  // ******************************************************************
  // Option byte and active snapshot
  // ******************************************************************
  // The stored byte models the option store: writes land here but the
  // pins follow only the copy taken at reset release, so a write takes
  // effect at the next reset.
  logic [7:0]     pin_remap_options_r = `AFRMUX_OPTIONS_RST;
  logic [7:0]     active_opts_r;
  logic           loaded_r;
  logic [7:0]     af_a_nxt;
  logic [7:0]     af_b_nxt;
  logic [7:0]     af_d_nxt;
  logic [7:0]     mask_a_nxt;
  logic [7:0]     mask_b_nxt;
  logic [7:0]     mask_d_nxt;
  afrmux_d0_sel_t d0_sel_nxt;
  afrmux_d0_sel_t d0_sel_r;
  logic           apb_acc;
  logic           apb_wr;

  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && pwrite && (paddr == `AFRMUX_OFS_OPTIONS);

  // The option store survives presetn like a non-volatile byte, so a
  // value written before a reset is what the pins follow after it.
  // Clearing it on reset would leave every remap option unreachable.
  always_ff @(posedge pclk) begin
    if (clk_en && apb_wr) begin
      pin_remap_options_r <= pwdata[7:0]; // see RULE1
    end
  end

  // Snapshot taken once, on the first enabled edge after release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_opts_r <= 8'h00;
      loaded_r      <= 1'b0;
    end else if (clk_en && !loaded_r) begin
      active_opts_r <= pin_remap_options_r; // see RULE15
      loaded_r      <= 1'b1;
    end
  end

  afrmux_route u_route (
    .opts                   (active_opts_r),
    .dflt_a                 (dflt_a),
    .dflt_b                 (dflt_b),
    .dflt_d                 (dflt_d),
    .beeper_output          (beeper_output),
    .twowire_sda            (twowire_sda),
    .twowire_scl            (twowire_scl),
    .advtimer_ext_trigger   (advtimer_ext_trigger),
    .advtimer_comp_out3     (advtimer_comp_out3),
    .advtimer_comp_out2     (advtimer_comp_out2),
    .advtimer_comp_out1     (advtimer_comp_out1),
    .advtimer_channel4      (advtimer_channel4),
    .advtimer_break_in      (advtimer_break_in),
    .configurable_clock_out (configurable_clock_out),
    .gptimer_b_channel1     (gptimer_b_channel1),
    .gptimer_a_channel3     (gptimer_a_channel3),
    .converter_ext_trigger  (converter_ext_trigger),
    .af_a                   (af_a_nxt),
    .af_b                   (af_b_nxt),
    .af_d                   (af_d_nxt),
    .remap_mask_a           (mask_a_nxt),
    .remap_mask_b           (mask_b_nxt),
    .remap_mask_d           (mask_d_nxt),
    .d0_sel                 (d0_sel_nxt)
  );

  // ******************************************************************
  // Registered pin outputs
  // ******************************************************************
  // Registering costs one cycle of latency on each routed function.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      af_a         <= 8'h00;
      af_b         <= 8'h00;
      af_d         <= 8'h00;
      remap_mask_a <= 8'h00;
      remap_mask_b <= 8'h00;
      remap_mask_d <= 8'h00;
      d0_sel_r     <= AFRMUX_D0_DEFAULT;
    end else if (clk_en) begin
      af_a         <= af_a_nxt; // see RULE2 see RULE13
      af_b         <= af_b_nxt;
      af_d         <= af_d_nxt;
      remap_mask_a <= mask_a_nxt;
      remap_mask_b <= mask_b_nxt;
      remap_mask_d <= mask_d_nxt;
      d0_sel_r     <= d0_sel_nxt;
    end
  end

  // ******************************************************************
  // APB slave
  // ******************************************************************
  // Zero wait states; unmapped addresses answer with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          `AFRMUX_OFS_OPTIONS: prdata <= {24'h000000, pin_remap_options_r};
          `AFRMUX_OFS_ACTIVE:  prdata <= {24'h000000, active_opts_r};
          `AFRMUX_OFS_PINSEL:  prdata <= {8'h00, remap_mask_d, remap_mask_b,
                                          remap_mask_a};
          default:             pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_beeper_route: assert property (clk_en && active_opts_r[7] |=> // see RULE3
    clk_en |-> af_d[4] == $past(beeper_output)) else $error("beeper route wrong");
  a_twowire_route: assert property (clk_en && active_opts_r[6] |=> // see RULE4
    clk_en |-> af_b[5:4] == {$past(twowire_sda), $past(twowire_scl)})
    else $error("two-wire route wrong");
  a_advb_route: assert property (clk_en && active_opts_r[5] |=> // see RULE5
    clk_en |-> remap_mask_b[3:0] == 4'hF && af_b[0] == $past(advtimer_comp_out1))
    else $error("port B timer route wrong");
  a_ch4_route: assert property (clk_en && active_opts_r[4] |=> // see RULE6
    clk_en |-> af_d[7] == $past(advtimer_channel4)) else $error("channel 4 route wrong");
  a_d0_priority: assert property (clk_en && active_opts_r[2] |=> // see RULE8 see RULE9
    clk_en |-> d0_sel_r == AFRMUX_D0_CLKOUT) else $error("clock out lost D0");
  a_break_route: assert property (clk_en && active_opts_r[3:2] == 2'h2 |=> // see RULE7
    clk_en |-> af_d[0] == $past(advtimer_break_in)) else $error("break route wrong");
  a_gpt_route: assert property (clk_en && active_opts_r[1] |=> // see RULE10
    clk_en |-> af_a[3] == $past(gptimer_b_channel1) && af_d[2] == $past(gptimer_a_channel3))
    else $error("timer channel route wrong");
  a_conv_route: assert property (clk_en && active_opts_r[0] |=> // see RULE11
    clk_en |-> af_d[3] == $past(converter_ext_trigger)) else $error("trigger route wrong");
  a_default_kept: assert property (clk_en && active_opts_r == 8'h00 |=> // see RULE2 see RULE13
    clk_en |-> af_b == $past(dflt_b) && remap_mask_d == 8'h00) else $error("default lost");
  a_opts_frozen: assert property (loaded_r |=> $stable(active_opts_r)) // see RULE15
    else $error("active options changed");
  a_opts_width: assert property (apb_wr && clk_en |=> // see RULE1
    pin_remap_options_r == $past(pwdata[7:0])) else $error("option write lost");

  c_beeper: cover property (loaded_r && active_opts_r[7]);
  c_both_d0: cover property (loaded_r && active_opts_r[3:2] == 2'h3);
  c_write: cover property (apb_wr && clk_en);
  c_unmapped: cover property (pslverr && pready);
endmodule // afrmux_top

// ===== dv/afrmux_bench.sv
// Self-checking testbench for the alternate function remap multiplexer.
`timescale 1ns/1ps
`include "afrmux_consts.svh"
module afrmux_bench;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  da, db, dd, af_a, af_b, af_d, m_a, m_b, m_d, cur_opts, xa, xb, xd;
  logic [12:0] fn;
  int          n_errors, n_compared;

  afrmux_top u_afrmux_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dflt_a(da), .dflt_b(db), .dflt_d(dd),
    .beeper_output(fn[0]), .twowire_sda(fn[1]), .twowire_scl(fn[2]),
    .advtimer_ext_trigger(fn[3]), .advtimer_comp_out3(fn[4]), .advtimer_comp_out2(fn[5]),
    .advtimer_comp_out1(fn[6]), .advtimer_channel4(fn[7]), .advtimer_break_in(fn[8]),
    .configurable_clock_out(fn[9]), .gptimer_b_channel1(fn[10]),
    .gptimer_a_channel3(fn[11]), .converter_ext_trigger(fn[12]), .af_a(af_a),
    .af_b(af_b), .af_d(af_d), .remap_mask_a(m_a), .remap_mask_b(m_b), .remap_mask_d(m_d));

  // ********************************************************************
  // Checking and bus helpers
  // ********************************************************************
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // Only the watchdog bounds this wait; the slave should answer at once.
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready wait", k, 32'h1);
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, addr, 32'h0, rd, e);
    chk("read data", rd, exp);
    chk("read error", {31'h0, e}, {31'h0, experr});
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd, input logic experr);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, addr, wd, rd, e);
    chk("write error", {31'h0, e}, {31'h0, experr});
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  // Expected pin map: each option overrides only its own pins, option 2 beats 3 on D0.
  task automatic model(input logic [7:0] o, input logic [12:0] f, input logic [7:0] d);
    logic [7:0] ea, eb, ed;
    ea = d;
    eb = ~d;
    ed = {d[3:0], d[7:4]};
    {xa, xb, xd} = 24'h0;
    if (o[7]) begin ed[4] = f[0]; xd[4] = 1'b1; end
    if (o[6]) begin eb[5:4] = {f[1], f[2]}; xb[5:4] = 2'h3; end
    if (o[5]) begin eb[3:0] = {f[3], f[4], f[5], f[6]}; xb[3:0] = 4'hF; end
    if (o[4]) begin ed[7] = f[7]; xd[7] = 1'b1; end
    if (o[2]) ed[0] = f[9];
    else if (o[3]) ed[0] = f[8];
    xd[0] = o[2] | o[3];
    if (o[1]) begin ea[3] = f[10]; ed[2] = f[11]; xa[3] = 1'b1; xd[2] = 1'b1; end
    if (o[0]) begin ed[3] = f[12]; xd[3] = 1'b1; end
    chk("pins a", {24'h0, af_a}, {24'h0, ea});
    chk("pins b", {24'h0, af_b}, {24'h0, eb});
    chk("pins d", {24'h0, af_d}, {24'h0, ed});
    chk("mask a", {24'h0, m_a}, {24'h0, xa});
    chk("mask b", {24'h0, m_b}, {24'h0, xb});
    chk("mask d", {24'h0, m_d}, {24'h0, xd});
  endtask

  task automatic route(input logic [12:0] f, input logic [7:0] d);
    @(posedge pclk);
    fn <= f;
    da <= d;
    db <= ~d;
    dd <= {d[3:0], d[7:4]};
    repeat (3) @(posedge pclk);
    #1;
    model(cur_opts, f, d);
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_regs();
    rd_chk(`AFRMUX_OFS_OPTIONS, 32'h0, 1'b0);
    route(13'h1555, 8'h5A);
    wr(`AFRMUX_OFS_OPTIONS, 32'hFFFF_FFA5, 1'b0);
    rd_chk(`AFRMUX_OFS_OPTIONS, 32'h0000_00A5, 1'b0);
    wr(`AFRMUX_OFS_ACTIVE, 32'h0000_00FF, 1'b0);
    rd_chk(`AFRMUX_OFS_ACTIVE, 32'h0, 1'b0);
    wr(12'h010, 32'h0000_0011, 1'b1);
    rd_chk(12'h010, 32'h0, 1'b1);
    rd_chk(`AFRMUX_OFS_OPTIONS, 32'h0000_00A5, 1'b0);
    route(13'h0333, 8'hC3);
    $display("test regs done, errors %0d", n_errors);
  endtask

  // Each option alone, then options 2 and 3 together; a write after reset must not move pins.
  task automatic t_remap();
    logic [7:0] o;
    for (int n = 0; n < 9; n++) begin
      o = (n < 8) ? (8'h01 << n) : 8'h0C;
      wr(`AFRMUX_OFS_OPTIONS, {24'h0, o}, 1'b0);
      do_reset();
      wr(`AFRMUX_OFS_OPTIONS, 32'h0, 1'b0);
      cur_opts = o;
      rd_chk(`AFRMUX_OFS_ACTIVE, {24'h0, o}, 1'b0);
      route(13'h1FFF, 8'h00);
      route(13'h0000, 8'hFF);
      route(13'h1555, 8'h5A);
      route(13'h0333, 8'hC3);
      rd_chk(`AFRMUX_OFS_PINSEL, {8'h00, xd, xb, xa}, 1'b0);
    end
    $display("test remap done, errors %0d", n_errors);
  endtask

  // With the clock enable low the pins must keep the old routing.
  task automatic t_freeze();
    route(13'h0AAA, 8'h3C);
    @(posedge pclk);
    clk_en <= 1'b0;
    fn <= 13'h1555;
    da <= 8'hC3;
    db <= 8'h3C;
    dd <= 8'h3C;
    repeat (3) @(posedge pclk);
    #1;
    model(cur_opts, 13'h0AAA, 8'h3C);
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    model(cur_opts, 13'h1555, 8'hC3);
    $display("test freeze done, errors %0d", n_errors);
  endtask

  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // The whole run needs well under two thousand cycles.
  initial begin
    #20000;
    n_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {da, db, dd, fn, cur_opts, n_errors, n_compared} = '0;
    clk_en = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_remap();
    t_freeze();
    finish_test();
  end
endmodule  // afrmux_bench
